// >>> rtl/aor_pkg.sv
package aor_pkg;

	// ---------------------------------------------------------------
	// Frame layout
	// ---------------------------------------------------------------
	localparam int          FRAME_BITS   = 16;
	localparam int          RESULT_W     = 16;
	localparam int          WR_POS       = 15;
	localparam int          ADDR_HI_POS  = 14;
	localparam int          ADDR_LO_POS  = 12;
	localparam int          NUM_W        = 4;
	localparam int          CNT_W        = 6;
	localparam logic [5:0]  CNT_RST      = 6'h00;
	localparam logic [5:0]  CNT_LAST_IN  = 6'h0F;
	localparam logic [5:0]  CNT_TOP      = 6'h20;

	// ---------------------------------------------------------------
	// Register numbers and reset values
	// ---------------------------------------------------------------
	localparam logic [3:0]  REG_CFG2     = 4'h2;
	localparam logic [3:0]  REG_FLAGS    = 4'h3;
	localparam logic [15:0] CFG2_RST     = 16'h0000;
	localparam logic [15:0] FLAGS_RST    = 16'h0000;
	localparam logic [15:0] WORD_ZERO    = 16'h0000;

	// ---------------------------------------------------------------
	// Output and reset configuration fields
	// ---------------------------------------------------------------
	localparam int          LANE_POS     = 8;
	localparam int          RCMD_W       = 8;
	localparam logic [7:0]  CMD_SOFT     = 8'h3C;
	localparam logic [7:0]  CMD_HARD     = 8'hFF;

	// ---------------------------------------------------------------
	// Fault and threshold flag positions
	// ---------------------------------------------------------------
	localparam int          SETUP_POS    = 8;
	localparam int          NUM_STICKY   = 5;
	localparam int          STICKY_POS [NUM_STICKY] = '{9, 5, 4, 1, 0};

endpackage

// >>> rtl/aor_sync.sv
`timescale 1ns/1ps
`default_nettype none

module aor_sync
	import aor_pkg::*;
#(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	// ---------------------------------------------------------------
	// Three stages, change accepted once stages two and three agree
	// ---------------------------------------------------------------
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] q_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_ff <= RST_VAL;
			s2_ff <= RST_VAL;
			s3_ff <= RST_VAL;
		end else begin
			s1_ff <= d;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	genvar i;
	for (i = 0; i < W; i++) begin : g_agree
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				q_ff[i] <= RST_VAL[i];
			end else if (s2_ff[i] == s3_ff[i]) begin
				q_ff[i] <= s3_ff[i];
			end
		end
	end

	assign q = q_ff;

endmodule

`default_nettype wire

// >>> rtl/aor_regs.sv
// Behaviour
// - register words carry the register number in bits 15 to 12.
// - lane select 0 splits results over primary and secondary outputs.
// - lane select 1 sends all results on the primary output alone.
// - code 0x3C in the reset field starts a soft reset, registers kept.
// - soft reset clears the sticky alert flags (not bit 8) and flushes oversampling and state machines.
// - code 0xFF performs a hard reset, registers return to defaults.
// - any other reset field value causes no reset action.
// - write-check failure sets sticky bit 9, cleared by an alert read.
// - a failed startup configuration load sets bit 8.
// - bit 8 survives alert reads; only hard reset clears and restarts setup.
// - channel two over-limit sets sticky bit 5 until an alert read.
// - channel two under-limit sets sticky bit 4 until an alert read.
// - configuration register is number 0x2 and reads zero after reset.
// - alert register is number 0x3, read only, zero after reset.
// - write bit set stores data bits 8 to 0 into the configuration register; bits 11 to 9 are dropped.
// - write bit clear on a valid register returns it next access.
// - secondary pin is alert only with one lane and alert enable.
// - channel one over and under flags sit at bits 1 and 0.
`timescale 1ns/1ps
`default_nettype none

module aor_regs
	import aor_pkg::*;
(
	// Clocks and reset
	input  wire logic                sys_clk,
	input  wire logic                rst,
	input  wire logic                link_sclk,
	// Serial link
	input  wire logic                frame_cs_n,
	input  wire logic                serial_data_in,
	output logic                     primary_data_out,
	output logic                     secondary_out_or_flag_pin,
	// Converter side
	input  wire logic [RESULT_W-1:0] chan1_result,
	input  wire logic [RESULT_W-1:0] chan2_result,
	input  wire logic                result_valid,
	input  wire logic                chan1_over_event,
	input  wire logic                chan1_under_event,
	input  wire logic                chan2_over_event,
	input  wire logic                chan2_under_event,
	input  wire logic                write_check_error,
	input  wire logic                setup_load_error,
	input  wire logic                alert_enable,
	// Control outputs
	output logic                     soft_flush_pulse,
	output logic                     hard_reset_pulse,
	output logic                     one_lane_mode
);

	// ---------------------------------------------------------------
	// Link domain: frame capture and shift out
	// ---------------------------------------------------------------
	logic                  frame_idle;
	logic [CNT_W-1:0]      bit_cnt_ff;
	logic [FRAME_BITS-2:0] rx_ff;
	logic [FRAME_BITS-1:0] frame_word_ff;
	logic                  frame_tgl_ff;
	logic [2*RESULT_W-1:0] pri_sh_ff;
	logic [RESULT_W-1:0]   sec_sh_ff;
	logic                  pri_out_ff;
	logic                  sec_out_ff;
	logic [1:0]            link_alert;
	logic [2*RESULT_W-1:0] tx_pri_ff;
	logic [RESULT_W-1:0]   tx_sec_ff;
	logic                  alert_mode_ff;
	logic                  alert_lvl_ff;

	// The link clock stops between frames, so the frame select ends the frame itself.
	assign frame_idle = rst | frame_cs_n;

	always_ff @(posedge link_sclk or posedge frame_idle) begin
		if (frame_idle) begin
			bit_cnt_ff <= CNT_RST;
			rx_ff      <= '0;
		end else begin
			if (bit_cnt_ff != CNT_TOP) begin
				bit_cnt_ff <= bit_cnt_ff + 6'h01;
			end
			if (bit_cnt_ff < CNT_LAST_IN) begin
				rx_ff <= {rx_ff[FRAME_BITS-3:0], serial_data_in};
			end
		end
	end

	// The word stays put until the next frame's sixteenth bit, long after the toggle is seen.
	always_ff @(posedge link_sclk or posedge rst) begin
		if (rst) begin
			frame_word_ff <= WORD_ZERO;
			frame_tgl_ff  <= 1'b0;
		end else if (!frame_cs_n && bit_cnt_ff == CNT_LAST_IN) begin
			frame_word_ff <= {rx_ff, serial_data_in};
			frame_tgl_ff  <= ~frame_tgl_ff;
		end
	end

	aor_sync #(
		.W       (2),
		.RST_VAL (2'b00)
	) u_link_alert_sync (
		.clk (link_sclk),
		.rst (rst),
		.d   ({alert_mode_ff, alert_lvl_ff}),
		.q   (link_alert)
	);

	// The transmit words are frozen while the frame select is low, so the load is safe.
	always_ff @(posedge link_sclk or posedge rst) begin
		if (rst) begin
			pri_sh_ff  <= '0;
			sec_sh_ff  <= '0;
			pri_out_ff <= 1'b0;
			sec_out_ff <= 1'b0;
		end else if (!frame_cs_n) begin
			if (bit_cnt_ff == CNT_RST) begin
				pri_out_ff <= tx_pri_ff[2*RESULT_W-1];
				pri_sh_ff  <= {tx_pri_ff[2*RESULT_W-2:0], 1'b0};
				sec_sh_ff  <= {tx_sec_ff[RESULT_W-2:0], 1'b0};
				sec_out_ff <= link_alert[1] ? link_alert[0] : tx_sec_ff[RESULT_W-1];
			end else begin
				pri_out_ff <= pri_sh_ff[2*RESULT_W-1];
				pri_sh_ff  <= {pri_sh_ff[2*RESULT_W-2:0], 1'b0};
				sec_sh_ff  <= {sec_sh_ff[RESULT_W-2:0], 1'b0};
				sec_out_ff <= link_alert[1] ? link_alert[0] : sec_sh_ff[RESULT_W-1];
			end
		end
	end

	assign primary_data_out          = pri_out_ff;
	assign secondary_out_or_flag_pin = sec_out_ff;

	// ---------------------------------------------------------------
	// System domain: frame arrival and decode
	// ---------------------------------------------------------------
	logic             cs_idle_s;
	logic             tgl_s;
	logic             tgl_seen_ff;
	logic             cs_idle_d_ff;
	logic             new_frame;
	logic             frame_start;
	logic             is_wr;
	logic [NUM_W-1:0] reg_num;
	logic [7:0]       cmd;
	logic             wr_cfg2;
	logic             rd_cfg2;
	logic             rd_flags;
	logic             do_soft;
	logic             do_hard;

	aor_sync #(
		.W       (2),
		.RST_VAL (2'b10)
	) u_frame_sync (
		.clk (sys_clk),
		.rst (rst),
		.d   ({frame_cs_n, frame_tgl_ff}),
		.q   ({cs_idle_s, tgl_s})
	);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tgl_seen_ff  <= 1'b0;
			cs_idle_d_ff <= 1'b1;
		end else begin
			tgl_seen_ff  <= tgl_s;
			cs_idle_d_ff <= cs_idle_s;
		end
	end

	assign new_frame   = tgl_s ^ tgl_seen_ff;
	assign frame_start = cs_idle_d_ff & ~cs_idle_s;
	assign is_wr       = frame_word_ff[WR_POS];
	assign reg_num     = {1'b0, frame_word_ff[ADDR_HI_POS:ADDR_LO_POS]};
	assign cmd         = frame_word_ff[RCMD_W-1:0];
	assign wr_cfg2     = new_frame & is_wr & (reg_num == REG_CFG2);
	assign rd_cfg2     = new_frame & ~is_wr & (reg_num == REG_CFG2);
	assign rd_flags    = new_frame & ~is_wr & (reg_num == REG_FLAGS);
	assign do_soft     = wr_cfg2 & (cmd == CMD_SOFT);
	assign do_hard     = wr_cfg2 & (cmd == CMD_HARD);

	// ---------------------------------------------------------------
	// Output and reset configuration register
	// ---------------------------------------------------------------
	logic             lane_ff;
	logic [7:0]       rcmd_ff;
	logic             soft_ff;
	logic             hard_ff;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lane_ff <= CFG2_RST[LANE_POS];
			rcmd_ff <= CFG2_RST[RCMD_W-1:0];
		end else if (do_hard) begin
			lane_ff <= CFG2_RST[LANE_POS];
			rcmd_ff <= CFG2_RST[RCMD_W-1:0];
		end else if (wr_cfg2) begin
			lane_ff <= frame_word_ff[LANE_POS];
			rcmd_ff <= cmd;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			soft_ff <= 1'b0;
			hard_ff <= 1'b0;
		end else begin
			soft_ff <= do_soft;
			hard_ff <= do_hard;
		end
	end

	assign soft_flush_pulse = soft_ff;
	assign hard_reset_pulse = hard_ff;
	assign one_lane_mode    = lane_ff;

	// ---------------------------------------------------------------
	// Fault and threshold flags
	// ---------------------------------------------------------------
	logic [NUM_STICKY-1:0] sticky_set;
	logic [NUM_STICKY-1:0] sticky_ff;
	logic                  sticky_clr;
	logic                  setup_ff;
	logic [15:0]           flags_word;
	logic [15:0]           cfg2_word;

	assign sticky_set = {chan1_under_event, chan1_over_event, chan2_under_event,
		chan2_over_event, write_check_error};
	assign sticky_clr = rd_flags | do_soft | do_hard;

	genvar gi;
	for (gi = 0; gi < NUM_STICKY; gi++) begin : g_sticky
		// A set arriving with a clear wins, so no event is lost.
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				sticky_ff[gi] <= FLAGS_RST[STICKY_POS[gi]];
			end else if (sticky_set[gi]) begin
				sticky_ff[gi] <= 1'b1;
			end else if (sticky_clr) begin
				sticky_ff[gi] <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			setup_ff <= FLAGS_RST[SETUP_POS];
		end else if (setup_load_error) begin
			setup_ff <= 1'b1;
		end else if (do_hard) begin
			setup_ff <= 1'b0;
		end
	end

	always_comb begin
		flags_word = {REG_FLAGS, 12'h000};
		for (int i = 0; i < NUM_STICKY; i++) begin
			flags_word[STICKY_POS[i]] = sticky_ff[i];
		end
		flags_word[SETUP_POS] = setup_ff;
	end

	assign cfg2_word = {REG_CFG2, 3'b000, lane_ff, rcmd_ff};

	// ---------------------------------------------------------------
	// Read snapshot and transmit words
	// ---------------------------------------------------------------
	logic                  pend_ff;
	logic [15:0]           rd_word_ff;
	logic [RESULT_W-1:0]   res1_ff;
	logic [RESULT_W-1:0]   res2_ff;

	// Snapshot at decode so flags cleared by this read are the ones returned.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pend_ff    <= 1'b0;
			rd_word_ff <= WORD_ZERO;
		end else if (rd_cfg2 || rd_flags) begin
			pend_ff    <= 1'b1;
			rd_word_ff <= rd_cfg2 ? cfg2_word : flags_word;
		end else if (new_frame || frame_start) begin
			pend_ff    <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			res1_ff <= '0;
			res2_ff <= '0;
		end else if (result_valid) begin
			res1_ff <= chan1_result;
			res2_ff <= chan2_result;
		end
	end

	// Frozen during a frame; the host must leave the select high a few system cycles.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_pri_ff <= '0;
			tx_sec_ff <= '0;
		end else if (cs_idle_s) begin
			if (pend_ff) begin
				tx_pri_ff <= {rd_word_ff, WORD_ZERO};
				tx_sec_ff <= WORD_ZERO;
			end else if (lane_ff) begin
				tx_pri_ff <= {res1_ff, res2_ff};
				tx_sec_ff <= WORD_ZERO;
			end else begin
				tx_pri_ff <= {res1_ff, WORD_ZERO};
				tx_sec_ff <= res2_ff;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			alert_mode_ff <= 1'b0;
			alert_lvl_ff  <= 1'b0;
		end else begin
			alert_mode_ff <= lane_ff & alert_enable;
			alert_lvl_ff  <= |sticky_ff[NUM_STICKY-1:1];
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	field_return_a: assert property (@(posedge sys_clk) disable iff (rst)
		(rd_cfg2 || rd_flags) |=> (rd_word_ff[15:12] == $past(reg_num)) && pend_ff)
		else $error("read snapshot lacks register number");

	two_lane_a: assert property (@(posedge sys_clk) disable iff (rst)
		(cs_idle_s && !pend_ff && !lane_ff) |=>
		(tx_sec_ff == $past(res2_ff)) && (tx_pri_ff[31:16] == $past(res1_ff)))
		else $error("two-lane split wrong");

	one_lane_a: assert property (@(posedge sys_clk) disable iff (rst)
		(cs_idle_s && !pend_ff && lane_ff) |=>
		(tx_pri_ff == {$past(res1_ff), $past(res2_ff)}) && (tx_sec_ff == WORD_ZERO))
		else $error("one-lane word wrong");

	soft_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
		do_soft |=> soft_flush_pulse && !hard_reset_pulse && (rcmd_ff == CMD_SOFT))
		else $error("soft reset not decoded");

	soft_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
		(do_soft && sticky_set == '0) |=> (sticky_ff == '0) ##1 !soft_flush_pulse)
		else $error("soft reset left flags set");

	hard_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
		(do_hard && !setup_load_error) |=>
		hard_reset_pulse && !lane_ff && (rcmd_ff == 8'h00) && !setup_ff)
		else $error("hard reset did not restore defaults");

	other_code_a: assert property (@(posedge sys_clk) disable iff (rst)
		(wr_cfg2 && cmd != CMD_SOFT && cmd != CMD_HARD) |=>
		!soft_flush_pulse && !hard_reset_pulse && (rcmd_ff == $past(cmd)))
		else $error("ignored code caused a reset");

	wchk_sticky_a: assert property (@(posedge sys_clk) disable iff (rst)
		(sticky_ff[0] && !sticky_clr) |=> sticky_ff[0])
		else $error("write-check flag dropped without read");

	setup_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
		(setup_ff && !do_hard) |=> setup_ff)
		else $error("setup flag cleared without hard reset");

	alert_pin_a: assert property (@(posedge link_sclk) disable iff (rst)
		(!frame_cs_n && link_alert[1]) |=> (secondary_out_or_flag_pin == $past(link_alert[0])))
		else $error("alert pin not showing alert level");

endmodule

`default_nettype wire

// >>> dv/aor_host.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Host serial port model
// ---------------------------------------------------------------
module aor_host (
	// Link
	output logic      link_sclk,
	output logic      frame_cs_n,
	output logic      serial_data_in,
	input  wire logic primary_data_out,
	input  wire logic secondary_out_or_flag_pin
);
	initial begin
		link_sclk      = 1'b0;
		frame_cs_n     = 1'b1;
		serial_data_in = 1'b0;
	end

	// The link clock stands still between frames, as a real host leaves it.
	// Both lanes are sampled at each falling edge, before the clock goes low.
	task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] ra,
		output logic [31:0] rb);
		ra         = '0;
		rb         = '0;
		// Frames start off the system clock grid, so the two clocks keep no fixed phase.
		#3 frame_cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			serial_data_in = tx[31-i];
			#16 link_sclk = 1'b1;
			#16 ra[31-i] = primary_data_out;
			rb[31-i]  = secondary_out_or_flag_pin;
			link_sclk = 1'b0;
		end
		#16 frame_cs_n = 1'b1;
		// A released data line must not keep its last value.
		serial_data_in = ~serial_data_in;
		#160;
	endtask
endmodule

`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
	import aor_pkg::*;

	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic                sys_clk, rst, link_sclk, frame_cs_n, serial_data_in;
	logic                primary_data_out, secondary_out_or_flag_pin;
	logic [RESULT_W-1:0] r1, r2;
	logic                result_valid, alert_enable;
	logic                soft_flush_pulse, hard_reset_pulse, one_lane_mode;
	// Event order: c1 under, c1 over, c2 under, c2 over, write check, setup.
	logic [5:0]          ev, e, s;
	logic [11:0]         d;
	logic [31:0]         ra, rb;
	int                  miscompares, cmp_count, soft_n, hard_n;

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	aor_regs dut (
		.sys_clk(sys_clk), .rst(rst), .link_sclk(link_sclk),
		.frame_cs_n(frame_cs_n), .serial_data_in(serial_data_in),
		.primary_data_out(primary_data_out),
		.secondary_out_or_flag_pin(secondary_out_or_flag_pin),
		.chan1_result(r1), .chan2_result(r2), .result_valid(result_valid),
		.chan1_over_event(ev[1]), .chan1_under_event(ev[0]),
		.chan2_over_event(ev[3]), .chan2_under_event(ev[2]),
		.write_check_error(ev[4]), .setup_load_error(ev[5]),
		.alert_enable(alert_enable), .soft_flush_pulse(soft_flush_pulse),
		.hard_reset_pulse(hard_reset_pulse), .one_lane_mode(one_lane_mode)
	);

	aor_host host (
		.link_sclk(link_sclk), .frame_cs_n(frame_cs_n), .serial_data_in(serial_data_in),
		.primary_data_out(primary_data_out),
		.secondary_out_or_flag_pin(secondary_out_or_flag_pin)
	);

	// Counted on the falling edge, where a pulse launched at the rising edge has settled.
	always @(negedge sys_clk) begin
		soft_n += (soft_flush_pulse === 1'b1);
		hard_n += (hard_reset_pulse === 1'b1);
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [15:0] cfgv(input logic l, input logic [7:0] c);
		return {REG_CFG2, 3'h0, l, c};
	endfunction

	function automatic logic [15:0] flagv(input logic [5:0] f);
		return {REG_FLAGS, 2'h0, f[4], f[5], 2'h0, f[3], f[2], 2'h0, f[1], f[0]};
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic frm(input logic [15:0] w);
		host.xfer({w, 16'h0000}, 16, ra, rb);
	endtask

	// The answer to a read comes out during the following frame.
	task automatic rd(input logic [3:0] n, input logic [15:0] exp);
		frm({1'b0, n[2:0], 12'h000});
		frm(16'h0000);
		check(ra[31:16], exp);
	endtask

	task automatic wr(input logic [3:0] n, input logic [11:0] v);
		frm({1'b1, n[2:0], v});
	endtask

	task automatic sys_pulse(input logic [5:0] f, input logic rv);
		@(posedge sys_clk);
		#1 ev = f;
		result_valid = rv;
		@(posedge sys_clk);
		#1 ev = '0;
		result_valid = 1'b0;
	endtask

	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		#400000;
		miscompares++;
		final_report();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(11175));
		rst = 1'b1;
		r1 = '0;
		r2 = '0;
		result_valid = 1'b0;
		alert_enable = 1'b0;
		ev = '0;
		s = '0;
		repeat (16) @(posedge sys_clk);
		#1 rst = 1'b0;
		repeat (8) @(posedge sys_clk);
		rd(REG_CFG2, cfgv(1'b0, 8'h00));
		rd(REG_FLAGS, flagv(6'h00));
		wr(REG_FLAGS, 12'hFFF);
		rd(REG_FLAGS, flagv(6'h00));
		for (int i = 0; i < 6; i++) begin
			d = 12'($urandom);
			if (i == 0) d = 12'hE3B;
			if (i == 1) d = 12'h1FE;
			if (d[7:0] == CMD_SOFT || d[7:0] == CMD_HARD) d[7:0] = 8'h00;
			wr(REG_CFG2, d);
			rd(REG_CFG2, cfgv(d[8], d[7:0]));
			check(32'(one_lane_mode), 32'(d[8]));
		end
		check(soft_n + hard_n, 0);
		for (int i = 0; i < 4; i++) begin
			e = (i == 0) ? 6'h3F : 6'($urandom) & 6'h1F;
			sys_pulse(e, 1'b0);
			rd(REG_FLAGS, flagv(e | s));
			s = (e | s) & 6'h20;
			rd(REG_FLAGS, flagv(s));
		end
		sys_pulse(6'h1F, 1'b0);
		wr(REG_CFG2, {4'h1, CMD_SOFT});
		check(soft_n, 1);
		check(hard_n, 0);
		rd(REG_FLAGS, flagv(s));
		rd(REG_CFG2, cfgv(1'b1, CMD_SOFT));
		// One lane with the alert function: results on the primary output alone.
		@(posedge sys_clk);
		#1 r1 = 16'($urandom);
		r2 = 16'($urandom);
		alert_enable = 1'b1;
		sys_pulse(6'h08, 1'b1);
		frm(16'h0000);
		host.xfer(32'h0, 32, ra, rb);
		check(ra, {r1, r2});
		check(32'(rb[0]), 32'h1);
		@(posedge sys_clk);
		#1 alert_enable = 1'b0;
		host.xfer(32'h0, 32, ra, rb);
		check(ra, {r1, r2});
		check(32'(rb[15:0]), 32'h0);
		rd(REG_FLAGS, flagv(6'h28));
		// Two lanes: the alert enable is ignored.
		wr(REG_CFG2, 12'h000);
		@(posedge sys_clk);
		#1 alert_enable = 1'b1;
		r1 = 16'hFFFF;
		r2 = 16'($urandom);
		sys_pulse(6'h01, 1'b1);
		frm(16'h0000);
		frm(16'h0000);
		check(ra[31:16], r1);
		check(rb[31:16], r2);
		wr(REG_CFG2, {4'h1, CMD_HARD});
		check(hard_n, 1);
		check(soft_n, 1);
		check(32'(one_lane_mode), 32'h0);
		rd(REG_CFG2, cfgv(1'b0, 8'h00));
		rd(REG_FLAGS, flagv(6'h00));
		final_report();
	end
endmodule

`default_nettype wire
